/* rtl/hall_code_decode.sv */
// Purpose: Combinational Hall code to driver command decode.
// Assumes: Code bit 2 is hall_in_1.
// Notes: Unused codes give all drivers off.
module hall_code_decode (
	input wire logic [2:0] i_code,
	output hall_commutation_pkg::drive_cmd_s o_cmd
);
	import hall_commutation_pkg::*;

	// ==========================================================
	// Truth table
	always_comb begin
		o_cmd = '{upper: DRV_RESET, lower: DRV_RESET};
		case (i_code)
			CODE_100: o_cmd = '{upper: 3'h4, lower: 3'h1}; // RQ1 RQ2
			CODE_110: o_cmd = '{upper: 3'h4, lower: 3'h2}; // RQ1 RQ2
			CODE_111: o_cmd = '{upper: 3'h1, lower: 3'h2}; // RQ1 RQ2
			CODE_011: o_cmd = '{upper: 3'h1, lower: 3'h4}; // RQ1 RQ2
			CODE_001: o_cmd = '{upper: 3'h2, lower: 3'h4}; // RQ1 RQ2
			CODE_000: o_cmd = '{upper: 3'h2, lower: 3'h1}; // RQ1 RQ2
			default: o_cmd = '{upper: DRV_RESET, lower: DRV_RESET}; // RQ11
		endcase
	end

endmodule : hall_code_decode

/* rtl/hall_commutation_pkg.sv */
// Purpose: Shared types and constants for the Hall commutation decoder.
// Assumes: Three Hall channels, three phases.
// Notes: Hall code bit 2 is hall_in_1, bit 0 is hall_in_3.
package hall_commutation_pkg;

	// ==========================================================
	// Widths and reset values
	localparam int NUM_PHASES = 3;
	localparam logic [2:0] DRV_RESET = 3'h0;
	localparam logic [2:0] HALL_RESET = 3'h0;

	// ==========================================================
	// Six valid Hall codes, order hall_in_1 hall_in_2 hall_in_3
	localparam logic [2:0] CODE_100 = 3'h4;
	localparam logic [2:0] CODE_110 = 3'h6;
	localparam logic [2:0] CODE_111 = 3'h7;
	localparam logic [2:0] CODE_011 = 3'h3;
	localparam logic [2:0] CODE_001 = 3'h1;
	localparam logic [2:0] CODE_000 = 3'h0;

	// ==========================================================
	// Differential Hall inputs, positive and negative per channel
	typedef struct packed {
		logic [2:0] pos;
		logic [2:0] neg;
	} hall_diff_s;

	// Driver commands, bit 0 is phase 1
	typedef struct packed {
		logic [2:0] upper;
		logic [2:0] lower;
	} drive_cmd_s;

	// Phase pin: output level and enable (enable high while driven)
	typedef struct packed {
		logic [2:0] level;
		logic [2:0] oe;
	} phase_pins_s;

endpackage : hall_commutation_pkg

/* rtl/three_phase_hall_commutation.sv */
// Purpose: Three-phase brushless motor commutation from Hall inputs.
// Assumes: Hall differential inputs (positive and negative halves) and inhibit come from pins, asynchronous to i_mclk.
// Notes: Inputs pass two flip-flops; outputs are registered.
// How it works
// RQ1 - Channel is one when positive exceeds negative; codes select the upper driver.
// RQ2 - Lower driver chosen from the same code; all other drivers off.
// RQ3 - A phase with neither driver on is released to high impedance.
// RQ4 - Sensors must be 30 degrees apart, rising in six-step order.
// RQ5 - Each input high under one of two 90 degree windows, 180 apart.
// RQ6 - Mismatched motors need an external reorder and inversion of sensors.
// RQ7 - Example motor: sensor_3, inverse sensor_1, sensor_2 feed channels one to three.
// RQ8 - Inversion done by using the negative input; spare inputs tied to reference.
// RQ9 - Inhibit high releases all three phases, overriding the decode.
// RQ10 - Index is open-collector copy of the first Hall channel.
// RQ11 - Unused codes turn all drivers off; never both drivers of one phase.
module three_phase_hall_commutation (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire hall_commutation_pkg::hall_diff_s i_hall,
	input wire logic i_inhibit,
	output hall_commutation_pkg::drive_cmd_s o_drive,
	output hall_commutation_pkg::phase_pins_s o_phase,
	output logic o_index_low,
	output logic o_index_oe
);
	import hall_commutation_pkg::*;

	// ==========================================================
	// State
	// Everything behind the pins lives in one registered struct
	typedef struct packed {
		hall_diff_s hall_meta;
		hall_diff_s hall_sync;
		logic [1:0] sync_full;
		logic inh_meta;
		logic inh_sync;
		logic [2:0] upper;
		logic [2:0] lower;
		logic [2:0] oe;
		logic index_oe;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic [2:0] chan;
	logic [2:0] code;
	drive_cmd_s cmd;
	logic drive_ok;

	// ==========================================================
	// Comparators
	// Both pin halves are synchronised first, so the comparison never
	// sees one half of a channel a cycle ahead of the other.
	// Channel high when positive input exceeds negative; feeding a sensor
	// into the negative half gives an inverted channel for free.
	for (genvar g = 0; g < NUM_PHASES; g++) begin : g_chan
		assign chan[g] = state_reg.hall_sync.pos[g] & ~state_reg.hall_sync.neg[g]; // RQ1 RQ8
	end

	// Channel 1 is the code's most significant bit
	assign code = {chan[0], chan[1], chan[2]};

	// Drivers may switch only once the synchroniser holds real pin data
	// and inhibit is low; the all-zero reset contents would decode as 000
	assign drive_ok = state_reg.sync_full[1] & ~state_reg.inh_sync;

	// Truth-table decode of the synchronised code
	hall_code_decode i_hall_code_decode (
		.i_code(code),
		.o_cmd(cmd)
	);

	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		// Two-stage synchronisers for the pins
		state_next.hall_meta = i_hall;
		state_next.hall_sync = state_reg.hall_meta;
		state_next.inh_meta = i_inhibit;
		state_next.inh_sync = state_reg.inh_meta;
		// Fill marker: a one walks in behind the first two pin samples
		state_next.sync_full = {state_reg.sync_full[0], 1'h1};
		if (drive_ok) begin
			state_next.upper = cmd.upper;
			state_next.lower = cmd.lower & ~cmd.upper; // RQ11
		end else begin
			state_next.upper = DRV_RESET; // RQ9
			state_next.lower = DRV_RESET; // RQ9
		end
		// Recirculating phase (no driver on) is released
		state_next.oe = state_next.upper | state_next.lower; // RQ3
		// Open collector pulls low while channel 1 is low; held off until filled
		state_next.index_oe = state_reg.sync_full[1] & ~chan[0]; // RQ10
	end

	// State register
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs
	assign o_drive = '{upper: state_reg.upper, lower: state_reg.lower};
	assign o_phase = '{level: state_reg.upper, oe: state_reg.oe};
	// Open-collector data: the index pin can only ever be pulled low
	assign o_index_low = 1'h0;
	assign o_index_oe = state_reg.index_oe;

	// ==========================================================
	// Assertions
	// Outputs trail the pins by three edges: two synchroniser stages
	// and the output register.
	property p_no_shoot_through;
		@(posedge i_mclk) disable iff (!i_resetn)
		(o_drive.upper & o_drive.lower) == 3'h0;
	endproperty
	a_no_shoot_through: assert property (p_no_shoot_through) // RQ11
		else $error("Upper and lower driver of one phase both on");

	property p_inhibit_release;
		@(posedge i_mclk) disable iff (!i_resetn)
		$rose(state_reg.inh_sync) |=> (o_phase.oe == 3'h0);
	endproperty
	a_inhibit_release: assert property (p_inhibit_release) // RQ9
		else $error("Phases not released one cycle after inhibit");

	property p_release_when_idle;
		@(posedge i_mclk) disable iff (!i_resetn)
		o_phase.oe == (o_drive.upper | o_drive.lower);
	endproperty
	a_release_when_idle: assert property (p_release_when_idle) // RQ3
		else $error("Phase enable does not match driver activity");

	property p_upper_map;
		@(posedge i_mclk) disable iff (!i_resetn)
		(!state_reg.inh_sync && code == 3'h4) |=> (o_drive.upper == 3'h4);
	endproperty
	a_upper_map: assert property (p_upper_map) // RQ1
		else $error("Code 100 did not select upper driver 3");

	property p_lower_map;
		@(posedge i_mclk) disable iff (!i_resetn)
		(!state_reg.inh_sync && code == 3'h3) |=> (o_drive.lower == 3'h4);
	endproperty
	a_lower_map: assert property (p_lower_map) // RQ2
		else $error("Code 011 did not select lower driver 3");

	property p_unused_off;
		@(posedge i_mclk) disable iff (!i_resetn)
		(code == 3'h2 || code == 3'h5) |=> (o_drive == '0);
	endproperty
	a_unused_off: assert property (p_unused_off) // RQ11
		else $error("Unused code left a driver on");

	property p_index_follow;
		@(posedge i_mclk) disable iff (!i_resetn)
		$fell(i_hall.pos[0] & ~i_hall.neg[0]) ##1
			(!(i_hall.pos[0] & ~i_hall.neg[0])) [*2] |=> o_index_oe;
	endproperty
	a_index_follow: assert property (p_index_follow) // RQ10
		else $error("Index not pulled low after channel 1 fell");

	property p_pin_latency;
		@(posedge i_mclk) disable iff (!i_resetn)
		(!i_inhibit && ((i_hall.pos & ~i_hall.neg) == 3'h7)) [*4] |-> (o_drive.upper == 3'h1);
	endproperty
	a_pin_latency: assert property (p_pin_latency) // RQ1
		else $error("Code 111 at pins did not reach upper driver 1");

	// Both drivers of a live step leave exactly one phase floating
	property p_one_phase_free;
		@(posedge i_mclk) disable iff (!i_resetn)
		(o_drive.upper != 3'h0) |-> ($countones(o_phase.oe) == 2);
	endproperty
	a_one_phase_free: assert property (p_one_phase_free) // RQ3
		else $error("Driven step did not leave exactly one phase released");

	// Inhibit keeps every phase released for as long as it is seen
	property p_inhibit_hold;
		@(posedge i_mclk) disable iff (!i_resetn)
		state_reg.inh_sync |=> (o_drive == '0 && o_phase.oe == 3'h0);
	endproperty
	a_inhibit_hold: assert property (p_inhibit_hold) // RQ9
		else $error("Driver switched on while inhibit was high");

	// Code 000 selects upper driver 2 and lower driver 1
	property p_code_000_map;
		@(posedge i_mclk) disable iff (!i_resetn)
		(drive_ok && code == 3'h0) |=> (o_drive.upper == 3'h2 && o_drive.lower == 3'h1);
	endproperty
	a_code_000_map: assert property (p_code_000_map) // RQ2
		else $error("Code 000 did not select upper 2 and lower 1");

	// At most one upper and one lower driver at any time
	property p_onehot_drive;
		@(posedge i_mclk) disable iff (!i_resetn)
		$onehot0(o_drive.upper) && $onehot0(o_drive.lower);
	endproperty
	a_onehot_drive: assert property (p_onehot_drive) // RQ1
		else $error("More than one upper or lower driver on");

	// Nothing switches before the synchroniser holds real pin data
	property p_fill_quiet;
		@(posedge i_mclk) disable iff (!i_resetn)
		!state_reg.sync_full[1] |=> (o_phase.oe == 3'h0 && !o_index_oe);
	endproperty
	a_fill_quiet: assert property (p_fill_quiet) // RQ11
		else $error("Output switched before the synchroniser filled");

	c_inhibit: cover property (@(posedge i_mclk) disable iff (!i_resetn) $rose(state_reg.inh_sync));
	c_step: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		code == 3'h4 ##[1:20] code == 3'h6);
	c_unused: cover property (@(posedge i_mclk) disable iff (!i_resetn) code == 3'h5);
	c_wrap: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		code == 3'h0 ##[1:20] code == 3'h4);
	c_index: cover property (@(posedge i_mclk) disable iff (!i_resetn) $rose(o_index_oe));

endmodule : three_phase_hall_commutation

/* tb/hall_sensor_model.sv */
// Purpose: Motor Hall sensors followed by a signal-set conversion stage.
// Assumes: One rotor step is 30 electrical degrees, twelve steps a turn.
// Notes: Force mode puts a raw code on the positive inputs, negatives low.
module hall_sensor_model (
	input wire logic [3:0] i_step,
	input wire logic i_force,
	input wire logic [2:0] i_code,
	output hall_commutation_pkg::hall_diff_s o_hall
);
	import hall_commutation_pkg::*;
	logic s1, s2, s3;
	// ==========================================================
	// Sensors high under two 90 degree windows placed 180 apart
	always_comb begin
		s3 = (i_step % 6) < 3;
		s1 = !(((i_step + 5) % 6) < 3);
		s2 = ((i_step + 4) % 6) < 3;
	end
	// ==========================================================
	// Reorder; sensor_1 inverted by feeding the negative input
	always_comb begin
		if (i_force) begin
			o_hall.pos = {i_code[0], i_code[1], i_code[2]};
			o_hall.neg = 3'h0;
		end else begin
			o_hall.pos = {s2, 1'h1, s3};
			o_hall.neg = {1'h0, s1, 1'h0};
		end
	end
endmodule : hall_sensor_model

/* tb/three_phase_hall_commutation_tb.sv */
// Purpose: Self-checking bench for the Hall commutation decoder.
// Assumes: Three-edge latency from any Hall or inhibit change to the outputs; reset clears them at once.
// Notes: Each check_all follows four edges of settle, outputs then stand still.
module three_phase_hall_commutation_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import hall_commutation_pkg::*;
	logic i_mclk = 1'h0, i_resetn = 1'h0, i_inhibit = 1'h0, force_raw = 1'h0;
	logic [3:0] step = 4'h0;
	logic [2:0] raw = 3'h0;
	logic o_index_low, o_index_oe;
	hall_diff_s hall;
	drive_cmd_s o_drive;
	phase_pins_s o_phase;
	int fail_count = 0, checks_done = 0;
	// Expected upper and lower per step, bit 0 is phase 1
	logic [2:0] up_t [6] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};
	logic [2:0] lo_t [6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1};
	// ==========================================================
	// Clock, partner and design
	initial forever #50 i_mclk = ~i_mclk;
	hall_sensor_model i_hall_sensor_model (.i_step(step), .i_force(force_raw), .i_code(raw),
		.o_hall(hall));
	three_phase_hall_commutation i_three_phase_hall_commutation (.i_mclk(i_mclk),
		.i_resetn(i_resetn), .i_hall(hall), .i_inhibit(i_inhibit), .o_drive(o_drive),
		.o_phase(o_phase), .o_index_low(o_index_low), .o_index_oe(o_index_oe));
	// ==========================================================
	// Shared compare and wait
	task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic settle();
		repeat (4) @(posedge i_mclk);
		#10;
	endtask : settle
	task automatic check_all(input logic [2:0] up, input logic [2:0] lo, input logic idx);
		check("upper", o_drive.upper, up);
		check("lower", o_drive.lower, lo);
		check("oe", o_phase.oe, up | lo);
		check("level", o_phase.level & o_phase.oe, up);
		check("index_oe", {2'h0, o_index_oe}, {2'h0, idx});
		check("index_low", {2'h0, o_index_low}, 3'h0);
	endtask : check_all
	// ==========================================================
	// Scenarios
	task automatic t_rotate();
		for (int p = 0; p < 12; p++) begin
			@(posedge i_mclk) step <= 4'(p);
			settle();
			check_all(up_t[p % 6], lo_t[p % 6], (p % 6) >= 3);
		end
	endtask : t_rotate
	task automatic t_unused();
		@(posedge i_mclk) force_raw <= 1'h1;
		raw <= 3'h2;
		settle();
		check_all(3'h0, 3'h0, 1'h1);
		@(posedge i_mclk) raw <= 3'h5;
		settle();
		check_all(3'h0, 3'h0, 1'h0);
		@(posedge i_mclk) force_raw <= 1'h0;
	endtask : t_unused
	task automatic t_inhibit();
		@(posedge i_mclk) step <= 4'h2;
		i_inhibit <= 1'h1;
		settle();
		check("oe inhibit", o_phase.oe, 3'h0);
		check("drive inhibit", o_drive.upper | o_drive.lower, 3'h0);
		@(posedge i_mclk) i_inhibit <= 1'h0;
		settle();
		check_all(up_t[2], lo_t[2], 1'h0);
	endtask : t_inhibit
	task automatic t_reset();
		@(posedge i_mclk) i_resetn <= 1'h0;
		#20;
		check("oe reset", o_phase.oe, 3'h0);
		check("drive reset", o_drive.upper | o_drive.lower, 3'h0);
		@(posedge i_mclk) i_resetn <= 1'h1;
		repeat (2) @(posedge i_mclk);
		#10;
		check("oe fill", o_phase.oe, 3'h0);
		check("index fill", {2'h0, o_index_oe}, 3'h0);
		settle();
		check_all(up_t[2], lo_t[2], 1'h0);
	endtask : t_reset
	// ==========================================================
	// Verdict, watchdog and main sequence
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (2000) @(posedge i_mclk);
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge i_mclk);
		check("oe in reset", o_phase.oe, 3'h0);
		i_resetn <= 1'h1;
		t_rotate();
		t_unused();
		t_inhibit();
		t_reset();
		end_of_test();
	end
endmodule : three_phase_hall_commutation_tb
